// ### hdl/dtr_pkg.sv
package dtr_pkg;

    // ----------------------------------------
    // Time base
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 10;       // System clock period, 100 MHz
    localparam int TICK_MS       = 10;       // Time-base tick period in ms
    localparam int TICK_CYCLES   = (TICK_MS * 1000000) / CLK_PERIOD_NS;
    localparam int DELAY_MAX_S   = 100;      // Longest interval in s
    localparam int DELAY_DEF_S   = 3;        // Interval after reset in s

    // ----------------------------------------
    // Interval fields
    // ----------------------------------------
    localparam int CNT_W = 14;               // Tick count width
    localparam logic [CNT_W-1:0] MAX_TICKS =
        CNT_W'((DELAY_MAX_S * 1000) / TICK_MS);
    localparam logic [CNT_W-1:0] DEF_TICKS =
        CNT_W'((DELAY_DEF_S * 1000) / TICK_MS);

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam int ADDR_W = 8;               // Decoded address width
    localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_ON_TIME  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_OFF_TIME = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h0C;

    // Function select in control bits [1:0]
    localparam logic [1:0] MODE_ON    = 2'h0;
    localparam logic [1:0] MODE_OFF   = 2'h1;
    localparam logic [1:0] MODE_ONOFF = 2'h2;
    localparam logic [1:0] MODE_RST   = 2'h0;

    // Status field positions
    localparam int ST_OUT_BIT  = 0;
    localparam int ST_TRG_BIT  = 1;
    localparam int ST_STATE_LO = 2;
    localparam int ST_CNT_LO   = 16;

    // Relay sequencer states
    typedef enum logic [3:0] {
        DTR_IDLE   = 4'h1,                   // Output low, no timing
        DTR_ONWAIT = 4'h2,                   // On interval running
        DTR_ACTIVE = 4'h4,                   // Output high, trigger high
        DTR_OFFWT  = 4'h8                    // Off interval running
    } dtr_state_e;

endpackage : dtr_pkg

// ### hdl/dtr_tick.sv
module dtr_tick #(
    parameter int TICK_CYCLES = dtr_pkg::TICK_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    output logic      tick_out
);
    import dtr_pkg::*;

    // ----------------------------------------
    // Free-running divider
    // ----------------------------------------
    localparam int DIV_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

    logic [DIV_W-1:0] div_reg;               // Cycle counter
    logic [DIV_W-1:0] div_next;
    logic             tick_reg;              // One-cycle tick pulse
    logic             tick_next;

    // Wrap at the last cycle, pulse once per period
    always_comb begin
        if (div_reg == DIV_LAST) begin
            div_next  = '0;
            tick_next = 1'b1;
        end else begin
            div_next  = div_reg + 1'b1;
            tick_next = 1'b0;
        end
    end

    // State registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            div_reg  <= div_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_out = tick_reg;

endmodule : dtr_tick

// ### hdl/dtr_relay.sv
module dtr_relay #(
    parameter int TICK_CYCLES = dtr_pkg::TICK_CYCLES
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [dtr_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      trig_in,
    input  wire logic                      clear_in,
    output logic                           relay_out
);
    import dtr_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [1:0]       mode_reg;              // Function select
    logic [1:0]       mode_next;
    logic [CNT_W-1:0] on_lim_reg;            // On interval in ticks
    logic [CNT_W-1:0] on_lim_next;
    logic [CNT_W-1:0] off_lim_reg;           // Off interval in ticks
    logic [CNT_W-1:0] off_lim_next;
    logic [31:0]      prdata_reg;            // Registered read data
    logic [31:0]      prdata_next;
    logic             pready_reg;            // Access-phase ready
    logic             pready_next;
    logic             pslverr_reg;           // Unmapped address flag
    logic             pslverr_next;

    dtr_state_e       state_reg;             // Sequencer state
    dtr_state_e       state_next;
    logic [CNT_W-1:0] cnt_reg;               // Elapsed ticks
    logic [CNT_W-1:0] cnt_next;
    logic             trg_prev_reg;          // Trigger one cycle ago
    logic             relay_reg;             // Relay output
    logic             relay_next;

    logic             tick;                  // Time-base pulse
    logic             wr_done;               // Write completes now
    logic             mode_wr;               // Function select written
    logic             is_off;                // Off-delay selected
    logic             is_onoff;              // On/off-delay selected
    logic             trg_rise;              // Trigger rising edge

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Clamp an interval write to the longest allowed
    function automatic logic [CNT_W-1:0] clamp_lim(input logic [31:0] v);
        if (v > 32'(MAX_TICKS)) begin
            return MAX_TICKS;
        end
        return v[CNT_W-1:0];
    endfunction : clamp_lim

    // Interval finished once the count reaches the limit
    function automatic logic expired(input logic [CNT_W-1:0] c,
                                     input logic [CNT_W-1:0] l);
        return c >= l;
    endfunction : expired

    // ----------------------------------------
    // Time base
    // ----------------------------------------
    dtr_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .tick_out (tick)
    );

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    assign wr_done = psel && penable && pready_reg && pwrite;
    assign mode_wr = wr_done && (paddr == OFS_CTRL);

    // Decode setup phase, answer in the first access cycle
    always_comb begin
        mode_next    = mode_reg;
        on_lim_next  = on_lim_reg;
        off_lim_next = off_lim_reg;
        prdata_next  = prdata_reg;
        pready_next  = psel && !penable;
        pslverr_next = 1'b0;
        // Setup cycle: prepare answer
        if (psel && !penable) begin
            prdata_next = '0;
            unique case (paddr)
                OFS_CTRL: begin
                    prdata_next[1:0] = mode_reg;
                end
                OFS_ON_TIME: begin
                    prdata_next[CNT_W-1:0] = on_lim_reg;
                end
                OFS_OFF_TIME: begin
                    prdata_next[CNT_W-1:0] = off_lim_reg;
                end
                OFS_STATUS: begin
                    prdata_next[ST_OUT_BIT]              = relay_reg;
                    prdata_next[ST_TRG_BIT]              = trig_in;
                    prdata_next[ST_STATE_LO+:4]          = state_reg;
                    prdata_next[ST_CNT_LO+:CNT_W]        = cnt_reg;
                end
                default: begin
                    pslverr_next = 1'b1;
                end
            endcase
        end
        // Access edge: write lands
        if (wr_done) begin
            unique case (paddr)
                OFS_CTRL: begin
                    mode_next = pwdata[1:0];
                end
                OFS_ON_TIME: begin
                    on_lim_next = clamp_lim(pwdata);
                end
                OFS_OFF_TIME: begin
                    off_lim_next = clamp_lim(pwdata);
                end
                default: begin
                    mode_next = mode_reg;
                end
            endcase
        end
    end

    // Register file and bus answer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg    <= MODE_RST;
            on_lim_reg  <= DEF_TICKS;
            off_lim_reg <= DEF_TICKS;
            prdata_reg  <= '0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            mode_reg    <= mode_next;
            on_lim_reg  <= on_lim_next;
            off_lim_reg <= off_lim_next;
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // ----------------------------------------
    // Relay sequencer
    // ----------------------------------------
    assign is_off   = (mode_reg == MODE_OFF);
    assign is_onoff = (mode_reg == MODE_ONOFF);
    assign trg_rise = trig_in && !trg_prev_reg;

    // Next state and elapsed count
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        // Count ticks while an interval runs
        if ((state_reg == DTR_ONWAIT || state_reg == DTR_OFFWT)
            && tick && cnt_reg != MAX_TICKS) begin
            cnt_next = cnt_reg + 1'b1;
        end
        unique case (state_reg)
            DTR_IDLE: begin
                cnt_next = '0;
                if (is_off && trig_in) begin
                    state_next = DTR_ACTIVE;
                end else if (!is_off && trg_rise) begin
                    state_next = DTR_ONWAIT;
                end
            end
            DTR_ONWAIT: begin
                if (!trig_in) begin
                    state_next = DTR_IDLE;
                    cnt_next   = '0;
                end else if (expired(cnt_reg, on_lim_reg)) begin
                    state_next = DTR_ACTIVE;
                    cnt_next   = '0;
                end
            end
            DTR_ACTIVE: begin
                cnt_next = '0;
                if (!trig_in) begin
                    if (is_off && clear_in) begin
                        state_next = DTR_IDLE;
                    end else if (is_off || is_onoff) begin
                        state_next = DTR_OFFWT;
                    end else begin
                        state_next = DTR_IDLE;
                    end
                end
            end
            DTR_OFFWT: begin
                if (trig_in) begin
                    state_next = DTR_ACTIVE;
                    cnt_next   = '0;
                end else if (is_off && clear_in) begin
                    state_next = DTR_IDLE;
                    cnt_next   = '0;
                end else if (expired(cnt_reg, off_lim_reg)) begin
                    state_next = DTR_IDLE;
                    cnt_next   = '0;
                end
            end
        endcase
        // New function starts from rest
        if (mode_wr) begin
            state_next = DTR_IDLE;
            cnt_next   = '0;
        end
        relay_next = (state_next == DTR_ACTIVE) || (state_next == DTR_OFFWT);
    end

    // Sequencer registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= DTR_IDLE;
            cnt_reg      <= '0;
            trg_prev_reg <= 1'b0;
            relay_reg    <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            trg_prev_reg <= trig_in;
            relay_reg    <= relay_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata    = prdata_reg;
    assign pready    = pready_reg;
    assign pslverr   = pslverr_reg;
    assign relay_out = relay_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_on_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !is_off && state_reg == DTR_IDLE && trg_rise && !mode_wr
        |=> state_reg == DTR_ONWAIT && cnt_reg == '0)
        else $error("on timing did not start on trigger rise");

    a_on_expire: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg == DTR_ONWAIT && trig_in && cnt_reg >= on_lim_reg && !mode_wr
        |=> relay_out)
        else $error("output not raised at on expiry");

    a_on_abort: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !is_off && !is_onoff && state_reg == DTR_ONWAIT && !trig_in
        |=> cnt_reg == '0 && !relay_out)
        else $error("on time not cleared on early fall");

    a_on_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !is_off && !is_onoff && !trig_in |=> !relay_out)
        else $error("on-delay output high with trigger low");

    a_lim_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
        on_lim_reg <= MAX_TICKS && off_lim_reg <= MAX_TICKS)
        else $error("interval above maximum");

    a_off_raise: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_off && trig_in && !mode_wr |=> relay_out)
        else $error("off-delay output not raised at once");

    a_off_expire: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg == DTR_OFFWT && !trig_in && cnt_reg >= off_lim_reg
        |=> !relay_out && state_reg == DTR_IDLE)
        else $error("output not lowered at off expiry");

    a_off_retrig: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_off && state_reg == DTR_OFFWT && trig_in && !mode_wr
        |=> state_reg == DTR_ACTIVE && cnt_reg == '0 && relay_out)
        else $error("off interval not restarted");

    a_off_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_off && clear_in && !trig_in |=> !relay_out && cnt_reg == '0)
        else $error("clear did not end off interval");

    a_onoff_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_onoff && state_reg == DTR_OFFWT && trig_in && !mode_wr
        |=> relay_out && cnt_reg == '0)
        else $error("off interval not cleared on rise");

    a_tick_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $changed(cnt_reg) && cnt_reg != '0 |-> $past(tick))
        else $error("count moved without a tick");

    a_zero_lim: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !is_off && on_lim_reg == '0 && trg_rise && state_reg == DTR_IDLE
        && !mode_wr ##1 trig_in && !mode_wr |=> relay_out)
        else $error("zero on interval added delay");

endmodule : dtr_relay

// ### sim/dtr_far_model.sv
module dtr_far_model (
    input  wire logic clk_sys,
    output logic      trig_in,
    output logic      clear_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Surrounding switching logic
    // ----------------------------------------
    // Both lines idle low until commanded
    initial begin
        trig_in  = 1'b0;
        clear_in = 1'b0;
    end

    // Levels change only just after a rising edge
    task automatic drive(input logic t, input logic c);
        @(posedge clk_sys);
        trig_in  <= t;
        clear_in <= c;
    endtask : drive
endmodule : dtr_far_model

// ### sim/tb.sv
module tb;
    import dtr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    localparam int TK = 4;              // Short tick for simulation
    logic        clk_sys = 1'b0;        // System clock
    logic        rst_n   = 1'b0;        // Reset, active low
    logic        psel    = 1'b0;        // APB select
    logic        penable = 1'b0;        // APB enable
    logic        pwrite  = 1'b0;        // APB direction
    logic [7:0]  paddr   = 8'h00;       // APB address
    logic [31:0] pwdata  = 32'h0;       // APB write data
    logic [31:0] prdata;                // APB read data
    logic        pready;                // APB ready
    logic        pslverr;               // APB error
    logic        trig_in;               // Trigger from far side
    logic        clear_in;              // Clear from far side
    logic        relay_out;             // Relay output
    logic [31:0] rd;                    // Last read word
    logic        er;                    // Last error flag
    int          error_cnt = 0;         // Mismatches
    int          tests_run = 0;         // Comparisons

    always #5 clk_sys = ~clk_sys;

    dtr_relay #(.TICK_CYCLES(TK)) dut_u (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trig_in(trig_in),
        .clear_in(clear_in), .relay_out(relay_out)
    );

    dtr_far_model far_u (.clk_sys(clk_sys), .trig_in(trig_in), .clear_in(clear_in));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1);
        chk("pready wait", 32'(k), 32'h1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Trigger low, then set intervals and function
    task automatic cfg(input logic [1:0] m, input int on_t, input int off_t);
        far_u.drive(1'b0, 1'b0);
        apb(1'b1, OFS_ON_TIME, 32'(on_t));
        apb(1'b1, OFS_OFF_TIME, 32'(off_t));
        apb(1'b1, OFS_CTRL, {30'h0, m});
        repeat (3) @(posedge clk_sys);
    endtask : cfg

    // Cycles until relay reaches lvl; L < 0 means at once
    task automatic meas(input logic lvl, input int L, input string nm);
        int n;
        int lo;
        int hi;
        n  = 0;
        lo = (L <= 0) ? 1 : (L - 1) * TK;
        hi = (L < 0) ? 3 : (L + 1) * TK + 4;
        while (relay_out !== lvl && n < 2000) begin
            @(negedge clk_sys);
            n++;
        end
        chk(nm, 32'(n >= lo && n <= hi), 32'h1);
    endtask : meas

    // Relay must keep lvl for n cycles
    task automatic hold(input logic lvl, input int n, input string nm);
        logic ok;
        ok = 1'b1;
        repeat (n) begin
            @(negedge clk_sys);
            if (relay_out !== lvl) ok = 1'b0;
        end
        chk(nm, 32'(ok), 32'h1);
    endtask : hold

    task automatic give_verdict;
        if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    // ----------------------------------------
    // Ordinary cases: function and intervals
    // ----------------------------------------
    typedef struct {
        logic [1:0] mode;
        int         on_t;
        int         off_t;
        int         rise_l;             // Expected rise delay in ticks
        int         fall_l;             // Expected fall delay in ticks
    } dtr_row_s;
    dtr_row_s rows[7] = '{'{MODE_ON, 5, 0, 5, -1}, '{MODE_ON, 0, 0, 0, -1},
        '{MODE_OFF, 0, 6, -1, 6}, '{MODE_OFF, 0, 0, -1, 0}, '{MODE_ONOFF, 3, 4, 3, 4},
        '{MODE_ONOFF, 0, 2, 0, 2}, '{2'h3, 2, 0, 2, -1}};

    // Watchdog cuts a hang short
    initial begin
        #400000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            cfg(rows[i].mode, rows[i].on_t, rows[i].off_t);
            far_u.drive(1'b1, 1'b0);
            meas(1'b1, rows[i].rise_l, "rise");
            far_u.drive(1'b0, 1'b0);
            meas(1'b0, rows[i].fall_l, "fall");
        end
        // Early fall clears on timing
        cfg(MODE_ON, 5, 0);
        far_u.drive(1'b1, 1'b0);
        hold(1'b0, 10, "on early");
        far_u.drive(1'b0, 1'b0);
        hold(1'b0, 4, "on low");
        far_u.drive(1'b1, 1'b0);
        meas(1'b1, 5, "on restart");
        // On/off: short pulse never raises output
        cfg(MODE_ONOFF, 5, 5);
        far_u.drive(1'b1, 1'b0);
        hold(1'b0, 10, "onoff early");
        far_u.drive(1'b0, 1'b0);
        hold(1'b0, 30, "onoff cleared");
        // On/off: rise raises output after the on interval
        far_u.drive(1'b1, 1'b0);
        meas(1'b1, 5, "onoff rise");
        // Clear has no effect in on/off function, early rise clears off timing
        far_u.drive(1'b0, 1'b1);
        hold(1'b1, 10, "onoff off run");
        far_u.drive(1'b1, 1'b0);
        hold(1'b1, 30, "onoff kept");
        far_u.drive(1'b0, 1'b0);
        meas(1'b0, 5, "onoff off full");
        // Off-delay retrigger restarts, clear cuts short
        cfg(MODE_OFF, 0, 5);
        far_u.drive(1'b1, 1'b0);
        meas(1'b1, -1, "off rise");
        far_u.drive(1'b0, 1'b0);
        hold(1'b1, 10, "off run");
        far_u.drive(1'b1, 1'b0);
        far_u.drive(1'b0, 1'b0);
        meas(1'b0, 5, "off restart");
        far_u.drive(1'b1, 1'b0);
        far_u.drive(1'b0, 1'b0);
        hold(1'b1, 4, "off before clear");
        far_u.drive(1'b0, 1'b1);
        meas(1'b0, -1, "off clear");
        far_u.drive(1'b0, 1'b0);
        // Clamp and unmapped access
        apb(1'b1, OFS_ON_TIME, 32'd10001);
        apb(1'b0, OFS_ON_TIME, 32'h0);
        chk("on clamp", rd, 32'(MAX_TICKS));
        apb(1'b1, 8'h10, 32'h0000_00FF);
        chk("unmapped wr err", 32'(er), 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped rd", rd, 32'h0);
        chk("unmapped rd err", 32'(er), 32'h1);
        // Mid-run reset with relay high restores defaults
        far_u.drive(1'b1, 1'b0);
        repeat (2) @(posedge clk_sys);
        chk("relay before reset", 32'(relay_out), 32'h1);
        rst_n <= 1'b0;
        far_u.drive(1'b0, 1'b0);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        chk("relay reset", 32'(relay_out), 32'h0);
        hold(1'b0, 2, "relay after reset");
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl reset", rd, 32'(MODE_RST));
        apb(1'b0, OFS_ON_TIME, 32'h0);
        chk("on reset", rd, 32'(DEF_TICKS));
        apb(1'b0, OFS_OFF_TIME, 32'h0);
        chk("off reset", rd, 32'(DEF_TICKS));
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status reset", rd, 32'(DTR_IDLE) << ST_STATE_LO);
        give_verdict();
    end
endmodule : tb
